/* File: rtl/mpsi_params.svh */
// Timing counts and fixed values for the modem power and status indicator block.
`ifndef MPSI_PARAMS_SVH
`define MPSI_PARAMS_SVH
`define MPSI_CLK_HZ          100000000
`define MPSI_TOGGLE_MS       3000
`define MPSI_TOGGLE_CYC      ((`MPSI_CLK_HZ / 1000) * `MPSI_TOGGLE_MS)
`define MPSI_FAST_ON_MS      500
`define MPSI_FAST_OFF_MS     500
`define MPSI_SLOW_ON_MS      300
`define MPSI_SLOW_OFF_MS     2700
`define MPSI_MS_CYC          (`MPSI_CLK_HZ / 1000)
`define MPSI_BOOT_SETTLE_CYC 4
`define MPSI_CNT_W           32
`endif

/* File: rtl/mpsi_pkg.sv */
// Types shared by the modem power and status indicator block.
package mpsi_pkg;
    typedef enum logic [1:0] {
        RADIO_OFF,
        RADIO_CALL,
        RADIO_SEARCH,
        RADIO_REGISTERED
    } mpsi_radio_type;

    typedef enum logic [2:0] {
        PWR_IDLE,
        PWR_ISOLATE,
        PWR_TOGGLE,
        PWR_SAMPLE,
        PWR_DONE
    } mpsi_pwr_type;

    typedef enum logic [1:0] {
        BOOT_WAIT,
        BOOT_RUN,
        BOOT_MONITOR
    } mpsi_boot_type;

    typedef struct packed {
        logic red;
        logic green;
        logic yellow;
    } mpsi_led_type;
endpackage

/* File: rtl/mpsi_sync.sv */
// Three-stage input synchroniser with agreement of the last two stages.
`timescale 1ns/1ps
module mpsi_sync
    import mpsi_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic RST_N_I,
    input  wire logic ce_i,
    input  wire logic d_i,
    output logic      q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } mpsi_sync_type;

    mpsi_sync_type st_r;
    mpsi_sync_type st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // A change counts only once the second and third stages agree.
        if (st_r.s2 == st_r.s3) begin
            st_nxt.q = st_r.s3;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_r <= '0;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.q;
endmodule

/* File: rtl/mpsi_blink.sv */
// Yellow LED pattern generator for the radio status.
`timescale 1ns/1ps
`include "mpsi_params.svh"
module mpsi_blink
    import mpsi_pkg::*;
(
    input  wire logic           CLK_I,
    input  wire logic           RST_N_I,
    input  wire logic           ce_i,
    input  wire mpsi_radio_type radio_i,
    output logic                led_o
);
    localparam logic [31:0] FAST_ON  = 32'(`MPSI_FAST_ON_MS * `MPSI_MS_CYC);
    localparam logic [31:0] FAST_OFF = 32'(`MPSI_FAST_OFF_MS * `MPSI_MS_CYC);
    localparam logic [31:0] SLOW_ON  = 32'(`MPSI_SLOW_ON_MS * `MPSI_MS_CYC);
    localparam logic [31:0] SLOW_OFF = 32'(`MPSI_SLOW_OFF_MS * `MPSI_MS_CYC);

    typedef struct packed {
        mpsi_radio_type sel;
        logic           on;
        logic [31:0]    cnt;
    } mpsi_blink_type;

    mpsi_blink_type st_r;
    mpsi_blink_type st_nxt;

    function automatic logic [31:0] phase_len(input mpsi_radio_type r, input logic on);
        if (r == RADIO_REGISTERED) begin
            phase_len = on ? SLOW_ON : SLOW_OFF;
        end else begin
            phase_len = on ? FAST_ON : FAST_OFF;
        end
    endfunction

    always_comb begin
        st_nxt     = st_r;
        st_nxt.sel = radio_i;
        if (radio_i != st_r.sel) begin
            // A new selection restarts its pattern at the start of an on phase.
            st_nxt.on  = 1'b1;
            st_nxt.cnt = '0;
        end else if (st_r.cnt >= phase_len(st_r.sel, st_r.on) - 32'h1) begin
            st_nxt.on  = ~st_r.on;
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_r <= '{sel: RADIO_OFF, on: 1'b1, cnt: 32'h0};
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // Steady states ignore the phase; blinking states show it.
    assign led_o = (st_r.sel == RADIO_CALL) ? 1'b1 :
                   (st_r.sel == RADIO_OFF)  ? 1'b0 : st_r.on;
endmodule

/* File: rtl/mpsi_top.sv */
// Modem power-off sequencer, boot mode decoder and status LED driver.
`timescale 1ns/1ps
`include "mpsi_params.svh"
module mpsi_top
    import mpsi_pkg::*;
(
    input  wire logic           CLK_I,
    input  wire logic           RST_N_I,
    input  wire logic           CE_I,
    input  wire logic           POWER_OFF_REQ_I,
    input  wire logic           POWER_MONITOR_LINE_I,
    input  wire logic           MODE_BUTTON_I,
    input  wire logic           BOOT_DONE_I,
    input  wire logic           BOOT_MEDIUM_FOUND_I,
    input  wire logic           APP_RED_I,
    input  wire logic           APP_GREEN_I,
    input  wire mpsi_radio_type RADIO_STATUS_I,
    output logic                POWER_TOGGLE_LINE_O,
    output logic                OUTPUT_ISOLATION_LINE_O,
    output logic                POWER_OFF_DONE_O,
    output logic                MODEM_OFF_O,
    output logic                MODE_BUTTON_INPUT_O,
    output logic                BOOTED_O,
    output logic                MONITOR_MODE_O,
    output logic                RED_LED_LINE_O,
    output logic                GREEN_LED_LINE_O,
    output logic                YELLOW_LED_O
);
    localparam logic [31:0] TOGGLE_CYC = 32'(`MPSI_TOGGLE_CYC);
    localparam logic [2:0]  SETTLE_CYC = 3'(`MPSI_BOOT_SETTLE_CYC);

    typedef struct packed {
        mpsi_pwr_type  pwr;
        mpsi_boot_type boot;
        logic [2:0]    settle;
        logic [31:0]   cnt;
        logic          toggle;
        logic          iso;
        logic          done;
        logic          modem_off;
        logic          mode_in;
        logic          booted;
        logic          monitor;
        mpsi_led_type  led;
    } mpsi_top_type;

    mpsi_top_type st_r;
    mpsi_top_type st_nxt;
    logic         pmon_s;
    logic         mode_s;
    logic         yellow;

    default clocking cb_main @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // True on the last cycle of a count that started at zero.
    function automatic logic count_end(input logic [31:0] cnt, input logic [31:0] len);
        count_end = (cnt >= len - 32'h1);
    endfunction

    mpsi_sync u_sync_pmon (
        .CLK_I   (CLK_I),
        .RST_N_I (RST_N_I),
        .ce_i    (CE_I),
        .d_i     (POWER_MONITOR_LINE_I),
        .q_o     (pmon_s)
    );

    mpsi_sync u_sync_mode (
        .CLK_I   (CLK_I),
        .RST_N_I (RST_N_I),
        .ce_i    (CE_I),
        .d_i     (MODE_BUTTON_I),
        .q_o     (mode_s)
    );

    mpsi_blink u_blink (
        .CLK_I   (CLK_I),
        .RST_N_I (RST_N_I),
        .ce_i    (CE_I),
        .radio_i (RADIO_STATUS_I),
        .led_o   (yellow)
    );

    always_comb begin
        st_nxt           = st_r;
        st_nxt.led.yellow = yellow;
        st_nxt.modem_off = pmon_s;
        st_nxt.done      = 1'b0;
        case (st_r.pwr)
            PWR_IDLE: begin
                if (POWER_OFF_REQ_I) begin
                    st_nxt.iso = 1'b1;
                    st_nxt.pwr = PWR_ISOLATE;
                end
            end
            PWR_ISOLATE: begin
                // Isolation settles one cycle before the toggle rises.
                st_nxt.toggle = 1'b1;
                st_nxt.cnt    = '0;
                st_nxt.pwr    = PWR_TOGGLE;
            end
            PWR_TOGGLE: begin
                if (count_end(st_r.cnt, TOGGLE_CYC)) begin
                    st_nxt.toggle = 1'b0;
                    st_nxt.pwr    = PWR_SAMPLE;
                end else begin
                    st_nxt.cnt = st_r.cnt + 32'h1;
                end
            end
            PWR_SAMPLE: begin
                // The modem may take a while to report off, so we wait for it.
                if (pmon_s) begin
                    st_nxt.done = 1'b1;
                    st_nxt.pwr  = PWR_DONE;
                end
            end
            PWR_DONE: begin
                if (!POWER_OFF_REQ_I) begin
                    st_nxt.pwr = PWR_IDLE;
                end
            end
            default: begin
                st_nxt.pwr = PWR_IDLE;
            end
        endcase
        case (st_r.boot)
            BOOT_WAIT: begin
                // The synchronisers restart with reset, so the button is judged only
                // after its level has had time to pass through them.
                if (st_r.settle != SETTLE_CYC) begin
                    st_nxt.settle = st_r.settle + 3'h1;
                end else if (mode_s) begin
                    st_nxt.boot      = BOOT_MONITOR;
                    st_nxt.monitor   = 1'b1;
                    st_nxt.led.green = 1'b1;
                end else begin
                    st_nxt.boot = BOOT_RUN;
                end
            end
            BOOT_RUN: begin
                if (!st_r.booted && BOOT_DONE_I) begin
                    if (BOOT_MEDIUM_FOUND_I) begin
                        st_nxt.booted = 1'b1;
                    end else begin
                        st_nxt.boot    = BOOT_MONITOR;
                        st_nxt.monitor = 1'b1;
                    end
                end
            end
            BOOT_MONITOR: begin
                st_nxt.monitor = 1'b1;
            end
            default: begin
                st_nxt.boot = BOOT_WAIT;
            end
        endcase
        if (st_r.booted) begin
            st_nxt.mode_in   = mode_s;
            st_nxt.led.red   = APP_RED_I;
            st_nxt.led.green = APP_GREEN_I;
        end else begin
            st_nxt.mode_in = 1'b0;
            st_nxt.led.red = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            // The whole unit restarts from this one reset.
            st_r         <= '0;
            st_r.pwr     <= PWR_IDLE;
            st_r.boot    <= BOOT_WAIT;
            st_r.led.red <= 1'b1;
        end else if (CE_I) begin
            st_r <= st_nxt;
        end
    end

    assign POWER_TOGGLE_LINE_O     = st_r.toggle;
    assign OUTPUT_ISOLATION_LINE_O = st_r.iso;
    assign POWER_OFF_DONE_O        = st_r.done;
    assign MODEM_OFF_O             = st_r.modem_off;
    assign MODE_BUTTON_INPUT_O     = st_r.mode_in;
    assign BOOTED_O                = st_r.booted;
    assign MONITOR_MODE_O          = st_r.monitor;
    assign RED_LED_LINE_O          = st_r.led.red;
    assign GREEN_LED_LINE_O        = st_r.led.green;
    assign YELLOW_LED_O            = st_r.led.yellow;

    sequence s_toggle_rise;
        $rose(st_r.toggle);
    endsequence

    sequence s_toggle_fall;
        $fell(st_r.toggle);
    endsequence

    sequence s_boot_ready;
        CE_I && st_r.boot == BOOT_WAIT && st_r.settle == SETTLE_CYC;
    endsequence

    sequence s_status_restart;
        CE_I && $past(CE_I) && $changed(RADIO_STATUS_I) && RADIO_STATUS_I != RADIO_OFF;
    endsequence

    a_iso_before_toggle: assert property (
        s_toggle_rise |-> st_r.iso)
        else $error("Toggle rose without isolation.");
    a_iso_sticky: assert property (
        st_r.iso |=> st_r.iso)
        else $error("Isolation dropped without reset.");
    a_toggle_needs_iso: assert property (
        st_r.toggle |-> st_r.iso)
        else $error("Toggle high without isolation.");
    a_toggle_min_hold: assert property (
        s_toggle_fall |-> count_end(st_r.cnt, TOGGLE_CYC))
        else $error("Toggle pulse too short.");
    a_toggle_from_zero: assert property (
        s_toggle_rise |-> st_r.cnt == 32'h0)
        else $error("Toggle count did not start from zero.");
    a_toggle_counts: assert property (
        (CE_I && st_r.toggle) |=> !st_r.toggle || st_r.cnt == $past(st_r.cnt) + 32'h1)
        else $error("Toggle count skipped a cycle.");
    a_sample_follows: assert property (
        s_toggle_fall |-> st_r.pwr == PWR_SAMPLE)
        else $error("Monitor not sampled after the toggle pulse.");
    a_done_needs_off: assert property (
        $rose(st_r.done) |-> $past(pmon_s) && $past(st_r.pwr) == PWR_SAMPLE)
        else $error("Power-down done without monitor high.");
    a_done_one_cycle: assert property (
        (CE_I && st_r.done) |=> !st_r.done)
        else $error("Done pulse longer than one cycle.");
    a_off_follows_mon: assert property (
        CE_I |=> st_r.modem_off == $past(pmon_s))
        else $error("Modem-off flag does not follow the monitor line.");

    a_red_during_boot: assert property (
        !st_r.booted |-> st_r.led.red)
        else $error("Red off during boot.");
    a_green_run_boot: assert property (
        (!st_r.booted && st_r.boot != BOOT_MONITOR) |-> !st_r.led.green)
        else $error("Green lit while booting to application.");
    a_run_no_button: assert property (
        s_boot_ready ##0 !mode_s |=> st_r.boot == BOOT_RUN && !st_r.led.green)
        else $error("Released mode button did not enter run mode.");
    a_run_booted: assert property (
        (CE_I && st_r.boot == BOOT_RUN && BOOT_DONE_I && BOOT_MEDIUM_FOUND_I) |=> st_r.booted)
        else $error("Medium found but application not booted.");
    a_wait_settle: assert property (
        (CE_I && st_r.boot == BOOT_WAIT && st_r.settle != SETTLE_CYC) |=> st_r.boot == BOOT_WAIT)
        else $error("Boot mode decided before the button settled.");
    a_nomedia_green: assert property (
        (CE_I && st_r.boot == BOOT_RUN && BOOT_DONE_I && !BOOT_MEDIUM_FOUND_I && !st_r.booted)
        |=> st_r.monitor && !st_r.led.green)
        else $error("No-medium fallback wrong.");
    a_monitor_sticky: assert property (
        st_r.monitor |=> st_r.monitor)
        else $error("Download mode left without reset.");
    a_monitor_unbooted: assert property (
        st_r.monitor |-> !st_r.booted)
        else $error("Download mode and application boot together.");
    a_mode_held_boot: assert property (
        (CE_I && st_r.boot == BOOT_WAIT && mode_s) |=> st_r.led.green && st_r.monitor)
        else $error("Held mode button did not enter download mode.");
    a_mode_readback: assert property (
        (CE_I && st_r.booted && mode_s) |=> st_r.mode_in)
        else $error("Mode button not reported high.");
    a_mode_quiet_boot: assert property (
        !st_r.booted |-> !st_r.mode_in)
        else $error("Mode button reported before boot.");
    a_mode_release: assert property (
        (CE_I && st_r.booted && !mode_s) |=> !st_r.mode_in)
        else $error("Mode button reported high while released.");
    a_app_red: assert property (
        (CE_I && st_r.booted) |=> st_r.led.red == $past(APP_RED_I))
        else $error("Red does not follow the application after boot.");
    a_app_green: assert property (
        (CE_I && st_r.booted) |=> st_r.led.green == $past(APP_GREEN_I))
        else $error("Green does not follow the application after boot.");

    a_yellow_call: assert property (
        (CE_I && RADIO_STATUS_I == RADIO_CALL) [*3] |=> st_r.led.yellow)
        else $error("Yellow not on during call.");
    a_yellow_off: assert property (
        (CE_I && RADIO_STATUS_I == RADIO_OFF) [*3] |=> !st_r.led.yellow)
        else $error("Yellow not off with the radio off.");
    a_yellow_restart: assert property (
        s_status_restart ##1 CE_I |=> st_r.led.yellow)
        else $error("Yellow pattern did not restart in its on phase.");
endmodule

/* File: test/mpsi_modem_model.sv */
// Behavioural model of the plug-in modem as seen from the power-off sequencer.
`timescale 1ns/1ps
module mpsi_modem_model #(
    parameter int HOLD_CYC = 300000000
) (
    input  wire logic clk_i,
    input  wire logic toggle_i,
    input  wire logic iso_i,
    input  wire logic off_cmd_i,
    output logic      monitor_o,
    output logic      order_err_o
);
    logic on_r  = 1'b1;
    logic err_r = 1'b0;
    int   cnt   = 0;

    // The modem has no tie to the board reset, so it keeps its power state.
    always @(posedge clk_i) begin
        if (toggle_i) begin
            cnt <= cnt + 1;
            if (!iso_i) begin
                err_r <= 1'b1;
            end
        end else if (cnt > 0) begin
            if (cnt >= HOLD_CYC) begin
                on_r <= !on_r;
            end
            cnt <= 0;
        end
        if (off_cmd_i) begin
            on_r <= 1'b0;
        end
    end

    assign order_err_o = err_r;
    assign monitor_o   = !on_r;
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the modem power and status indicator block.
`timescale 1ns/1ps
module tb_top
    import mpsi_pkg::*;
;
    typedef struct packed {
        logic btn, med, app_red, app_green;
        logic exp_booted, exp_mon, exp_red, exp_green;
    } mpsi_row_type;

    // Boot cases: button, medium, application LEDs, then expected results.
    localparam logic [7:0] ROWS [4] = '{8'h59, 8'h36, 8'hC7, 8'h6A};

    logic CLK_I, RST_N_I, CE_I, POWER_OFF_REQ_I, POWER_MONITOR_LINE_I, MODE_BUTTON_I;
    logic BOOT_DONE_I, BOOT_MEDIUM_FOUND_I, APP_RED_I, APP_GREEN_I;
    mpsi_radio_type RADIO_STATUS_I;
    logic POWER_TOGGLE_LINE_O, OUTPUT_ISOLATION_LINE_O, POWER_OFF_DONE_O, MODEM_OFF_O;
    logic MODE_BUTTON_INPUT_O, BOOTED_O, MONITOR_MODE_O;
    logic RED_LED_LINE_O, GREEN_LED_LINE_O, YELLOW_LED_O;
    logic off_cmd, order_err;
    int   n_mismatch = 0;
    int   n_checks   = 0;
    mpsi_row_type row;

    mpsi_top dut (
        .CLK_I, .RST_N_I, .CE_I, .POWER_OFF_REQ_I, .POWER_MONITOR_LINE_I, .MODE_BUTTON_I,
        .BOOT_DONE_I, .BOOT_MEDIUM_FOUND_I, .APP_RED_I, .APP_GREEN_I, .RADIO_STATUS_I,
        .POWER_TOGGLE_LINE_O, .OUTPUT_ISOLATION_LINE_O, .POWER_OFF_DONE_O, .MODEM_OFF_O,
        .MODE_BUTTON_INPUT_O, .BOOTED_O, .MONITOR_MODE_O,
        .RED_LED_LINE_O, .GREEN_LED_LINE_O, .YELLOW_LED_O
    );

    mpsi_modem_model modem (
        .clk_i       (CLK_I),
        .toggle_i    (POWER_TOGGLE_LINE_O),
        .iso_i       (OUTPUT_ISOLATION_LINE_O),
        .off_cmd_i   (off_cmd),
        .monitor_o   (POWER_MONITOR_LINE_I),
        .order_err_o (order_err)
    );

    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Watches the yellow line for n cycles and reports any departure once.
    task automatic hold_yellow(input logic exp, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            step(1);
            if (YELLOW_LED_O !== exp) bad = 1'b1;
        end
        chk1(bad, 1'b0);
    endtask

    initial begin
        repeat (90000) @(posedge CLK_I);
        n_mismatch++;
        stop_test();
    end

    initial begin
        RST_N_I = 1'b0; CE_I = 1'b1; POWER_OFF_REQ_I = 1'b0; MODE_BUTTON_I = 1'b0;
        BOOT_DONE_I = 1'b0; BOOT_MEDIUM_FOUND_I = 1'b0; APP_RED_I = 1'b0;
        APP_GREEN_I = 1'b0; RADIO_STATUS_I = RADIO_OFF; off_cmd = 1'b0;
        for (int i = 0; i < 4; i++) begin
            row = mpsi_row_type'(ROWS[i]);
            RST_N_I = 1'b0; BOOT_DONE_I = 1'b0; MODE_BUTTON_I = row.btn;
            BOOT_MEDIUM_FOUND_I = row.med; APP_RED_I = row.app_red;
            APP_GREEN_I = row.app_green;
            step(6);
            chk1(RED_LED_LINE_O, 1'b1);
            chk1(GREEN_LED_LINE_O, 1'b0);
            chk1(BOOTED_O, 1'b0);
            RST_N_I = 1'b1;
            step(8);
            MODE_BUTTON_I = 1'b0;
            step(2);
            chk1(RED_LED_LINE_O, 1'b1);
            BOOT_DONE_I = 1'b1;
            step(6);
            chk1(BOOTED_O, row.exp_booted);
            chk1(MONITOR_MODE_O, row.exp_mon);
            chk1(RED_LED_LINE_O, row.exp_red);
            chk1(GREEN_LED_LINE_O, row.exp_green);
        end
        // Run mode from the last row: the button now reaches the application.
        MODE_BUTTON_I = 1'b1;
        step(6);
        chk1(MODE_BUTTON_INPUT_O, 1'b1);
        MODE_BUTTON_I = 1'b0;
        step(6);
        chk1(MODE_BUTTON_INPUT_O, 1'b0);
        // Blink phases run for millions of cycles, so only the opening on phase fits here.
        for (int k = 0; k < 4; k++) begin
            RADIO_STATUS_I = mpsi_radio_type'(k[1:0]);
            step(4);
            hold_yellow(k != 0, 2000);
        end
        RADIO_STATUS_I = RADIO_SEARCH;
        step(4);
        chk1(YELLOW_LED_O, 1'b1);
        CE_I = 1'b0;
        MODE_BUTTON_I = 1'b1;
        step(8);
        chk1(MODE_BUTTON_INPUT_O, 1'b0);
        CE_I = 1'b1;
        step(6);
        chk1(MODE_BUTTON_INPUT_O, 1'b1);
        MODE_BUTTON_I = 1'b0;
        // Power-off: isolation must lead the toggle pulse.
        POWER_OFF_REQ_I = 1'b1;
        for (int w = 0; w < 4 && OUTPUT_ISOLATION_LINE_O !== 1'b1; w++) step(1);
        chk1(OUTPUT_ISOLATION_LINE_O, 1'b1);
        chk1(POWER_TOGGLE_LINE_O, 1'b0);
        step(1);
        chk1(POWER_TOGGLE_LINE_O, 1'b1);
        POWER_OFF_REQ_I = 1'b0;
        step(2);
        POWER_OFF_REQ_I = 1'b1;
        step(50000);
        chk1(POWER_TOGGLE_LINE_O, 1'b1);
        chk1(POWER_OFF_DONE_O, 1'b0);
        chk1(MODEM_OFF_O, 1'b0);
        POWER_OFF_REQ_I = 1'b0;
        RST_N_I = 1'b0;
        step(2);
        chk1(POWER_TOGGLE_LINE_O, 1'b0);
        chk1(OUTPUT_ISOLATION_LINE_O, 1'b0);
        RST_N_I = 1'b1;
        step(6);
        chk1(MODEM_OFF_O, 1'b0);
        // The modem shuts itself down; no sequence ran, so no completion pulse.
        off_cmd = 1'b1;
        step(6);
        chk1(MODEM_OFF_O, 1'b1);
        chk1(POWER_OFF_DONE_O, 1'b0);
        chk1(order_err, 1'b0);
        stop_test();
    end
endmodule
